// [rtl/acc_filter_regs.svh]
`ifndef ACC_FILTER_REGS_SVH
`define ACC_FILTER_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MODE_OFS       12'h000
`define SCALE_OFS      12'h004
`define FIFO_SEL_OFS   12'h008
`define ACTIVE_OFS     12'h00C
`define QUEUE_PAGE     6'h01
`define Q_CTRL_OFS     5'h00
`define Q_ID_OFS       5'h04
`define Q_PROP_OFS     5'h08
`define Q_DLO_OFS      5'h0C
`define Q_DHI_OFS      5'h10
`define BANK_PAGE      4'h1

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define NUM_BANKS      28
`define BANK_IDX_W     5
`define SLOT_W         7
`define FIFO_DEPTH     16
`define LEVEL_W        5
`define RELEASE_BIT    5
`define FULL_BIT       6
`define PROP_SLOT_LSB  8
`define CFG_RST        28'h0000000
`define WORD_RST       32'h00000000

`endif

// [rtl/acc_filter_pkg.sv]
package acc_filter_pkg;

  typedef struct packed {
    logic [10:0] standard_id_bits;
    logic [17:0] extended_id_bits;
    logic        frame_format_bit;
    logic        frame_type_bit;
    logic [3:0]  dlc;
    logic [31:0] data_lo;
    logic [31:0] data_hi;
  } rx_frame_t;

  typedef struct packed {
    rx_frame_t   frame;
    logic [7:0]  matched_slot_number;
  } rx_entry_t;

endpackage : acc_filter_pkg

// [rtl/can_rx_acceptance_filter.sv]
// Functional notes
// - Store only passing frames, drop others silently
// - Match identifier plus format and type bits
// - 28 banks, two 32-bit words each
// - Per-bank choice of 32 or 16-bit scale
// - 32-bit: std, extended, format, type bits
// - 16-bit: std, type, format, top ext bits
// - Mask mode compares only masked-in bits
// - List mode: any exact entry passes
// - 32-bit mask one number, list two
// - Bank routes passing frames to its FIFO
// - Only active banks take part in matching
// - Matched filter number stored with frame
// - Numbers allocated for inactive banks too
// - Priority: 32-bit, list, then lower number
// - Release removes oldest frame from FIFO
`timescale 1ns/1ps
`include "acc_filter_regs.svh"

// ----------------------------------------
// Frame FIFO
// ----------------------------------------
module frame_fifo #(
  parameter int W  = 8,
  parameter int D  = 16,
  parameter int AW = $clog2(D)
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [AW:0]        level
);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          wr;
  logic          rd;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign level     = cnt_r;
  assign wr        = in_valid & in_ready;
  assign rd        = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (wr) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd) begin
        rp_r <= rp_r + 1'b1;
      end
      if (wr && !rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (rd && !wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : frame_fifo

// ----------------------------------------
// Acceptance filter top
// ----------------------------------------
module can_rx_acceptance_filter
  import acc_filter_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_valid,
  output logic             frame_ready,
  input  wire rx_frame_t   frame_in
);
  localparam int NB = `NUM_BANKS;
  localparam int SW = `SLOT_W;

  logic [NB-1:0]  list_mode_r;
  logic [NB-1:0]  scale32_r;
  logic [NB-1:0]  fifo_sel_r;
  logic [NB-1:0]  active_r;
  logic [31:0]    word_lo_r [NB];
  logic [31:0]    word_hi_r [NB];
  logic [31:0]    prdata_r;
  logic           pready_r;
  logic           pslverr_r;
  logic           frame_ready_r;
  rx_frame_t      stage_r;
  logic           stage_v_r;

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign frame_ready = frame_ready_r;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic            setup;
  logic            wr_en;
  logic            bank_hit;
  logic            q_hit;
  logic [4:0]      bank_idx;
  logic            q_idx;
  logic [31:0]     rd_data;
  logic            rd_ok;
  logic [1:0]      release_req;
  rx_entry_t       q_head [2];
  logic [`LEVEL_W-1:0] q_level [2];

  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pwrite & pready_r;
  assign bank_idx = paddr[7:3];
  assign q_idx    = paddr[5];
  assign bank_hit = (paddr[11:8] == `BANK_PAGE) && (bank_idx < 5'(NB)) && (paddr[1:0] == 2'h0);
  assign q_hit    = (paddr[11:6] == `QUEUE_PAGE) && (paddr[1:0] == 2'h0) && (paddr[4:0] <= `Q_DHI_OFS);

  always_comb begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (bank_hit) begin
      rd_data = paddr[2] ? word_hi_r[bank_idx] : word_lo_r[bank_idx];
    end else if (q_hit) begin
      unique case (paddr[4:0])
        `Q_CTRL_OFS: begin
          rd_data[`LEVEL_W-1:0] = q_level[q_idx];
          rd_data[`FULL_BIT]    = (q_level[q_idx] == `LEVEL_W'(`FIFO_DEPTH));
        end
        `Q_ID_OFS: begin
          rd_data = {q_head[q_idx].frame.standard_id_bits, q_head[q_idx].frame.extended_id_bits,
                     q_head[q_idx].frame.frame_format_bit, q_head[q_idx].frame.frame_type_bit, 1'b0};
        end
        `Q_PROP_OFS: begin
          rd_data[3:0] = q_head[q_idx].frame.dlc;
          rd_data[`PROP_SLOT_LSB +: 8] = q_head[q_idx].matched_slot_number;
        end
        `Q_DLO_OFS: begin
          rd_data = q_head[q_idx].frame.data_lo;
        end
        `Q_DHI_OFS: begin
          rd_data = q_head[q_idx].frame.data_hi;
        end
        default: begin
          rd_ok = 1'b0;
        end
      endcase
    end else begin
      unique case (paddr)
        `MODE_OFS:     rd_data[NB-1:0] = list_mode_r;
        `SCALE_OFS:    rd_data[NB-1:0] = scale32_r;
        `FIFO_SEL_OFS: rd_data[NB-1:0] = fifo_sel_r;
        `ACTIVE_OFS:   rd_data[NB-1:0] = active_r;
        default:       rd_ok = 1'b0;
      endcase
    end
  end

  // Zero-wait answer: pready rises in the access phase
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~rd_ok;
      if (setup) begin
        prdata_r <= pwrite ? 32'h00000000 : rd_data;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      list_mode_r <= `CFG_RST;
      scale32_r   <= `CFG_RST;
      fifo_sel_r  <= `CFG_RST;
      active_r    <= `CFG_RST;
    end else if (wr_en && !bank_hit && !q_hit) begin
      unique case (paddr)
        `MODE_OFS:     list_mode_r <= pwdata[NB-1:0];
        `SCALE_OFS:    scale32_r   <= pwdata[NB-1:0];
        `FIFO_SEL_OFS: fifo_sel_r  <= pwdata[NB-1:0];
        `ACTIVE_OFS:   active_r    <= pwdata[NB-1:0];
        default: begin
        end
      endcase
    end
  end

  // Release is a write-one pulse; an empty queue ignores it
  assign release_req[0] = wr_en & q_hit & ~q_idx & (paddr[4:0] == `Q_CTRL_OFS) & pwdata[`RELEASE_BIT];
  assign release_req[1] = wr_en & q_hit & q_idx & (paddr[4:0] == `Q_CTRL_OFS) & pwdata[`RELEASE_BIT];

  // ----------------------------------------
  // Per-bank match
  // ----------------------------------------
  logic [31:0]   key32;
  logic [15:0]   key16;
  logic [3:0]    hit [NB];
  logic [1:0]    cls [NB];
  logic [SW-1:0] cnt [NB];
  logic [SW-1:0] elem [NB];
  logic [SW-1:0] slot [NB];
  logic [SW-1:0] base0 [NB+1];
  logic [SW-1:0] base1 [NB+1];

  assign key32 = {stage_r.standard_id_bits, stage_r.extended_id_bits,
                  stage_r.frame_format_bit, stage_r.frame_type_bit, 1'b0};
  assign key16 = {stage_r.standard_id_bits, stage_r.frame_type_bit,
                  stage_r.frame_format_bit, stage_r.extended_id_bits[17:15]};
  assign base0[0] = '0;
  assign base1[0] = '0;

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bank
      logic [3:0] raw;

      // Two words per bank, written from the bus
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          word_lo_r[b] <= `WORD_RST;
          word_hi_r[b] <= `WORD_RST;
        end else if (wr_en && bank_hit && bank_idx == 5'(b)) begin
          if (paddr[2]) begin
            word_hi_r[b] <= pwdata;
          end else begin
            word_lo_r[b] <= pwdata;
          end
        end
      end

      always_comb begin
        raw = 4'h0;
        if (scale32_r[b]) begin
          if (list_mode_r[b]) begin
            raw[0] = (key32 == word_lo_r[b]);
            raw[1] = (key32 == word_hi_r[b]);
          end else begin
            raw[0] = (((key32 ^ word_lo_r[b]) & word_hi_r[b]) == 32'h00000000);
          end
        end else if (list_mode_r[b]) begin
          raw[0] = (key16 == word_lo_r[b][15:0]);
          raw[1] = (key16 == word_lo_r[b][31:16]);
          raw[2] = (key16 == word_hi_r[b][15:0]);
          raw[3] = (key16 == word_hi_r[b][31:16]);
        end else begin
          raw[0] = (((key16 ^ word_lo_r[b][15:0]) & word_lo_r[b][31:16]) == 16'h0000);
          raw[1] = (((key16 ^ word_hi_r[b][15:0]) & word_hi_r[b][31:16]) == 16'h0000);
        end
      end

      assign hit[b] = active_r[b] ? raw : 4'h0;
      assign cls[b] = {scale32_r[b], list_mode_r[b]};

      // Count of filter numbers the bank occupies
      assign cnt[b] = scale32_r[b] ? (list_mode_r[b] ? SW'(2) : SW'(1))
                                   : (list_mode_r[b] ? SW'(4) : SW'(2));

      // Inactive banks still consume numbers
      assign base0[b+1] = base0[b] + (fifo_sel_r[b] ? SW'(0) : cnt[b]);
      assign base1[b+1] = base1[b] + (fifo_sel_r[b] ? cnt[b] : SW'(0));

      assign elem[b] = raw[0] ? SW'(0) : raw[1] ? SW'(1) : raw[2] ? SW'(2) : SW'(3);
      assign slot[b] = (fifo_sel_r[b] ? base1[b] : base0[b]) + elem[b];
    end
  endgenerate

  // ----------------------------------------
  // Winner select
  // ----------------------------------------
  logic                   best_v;
  logic [1:0]             best_cls;
  logic [`BANK_IDX_W-1:0] best_b;

  // Descending scan with >= keeps the lowest bank on a tie
  always_comb begin
    best_v   = 1'b0;
    best_cls = 2'h0;
    best_b   = '0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (hit[i] != 4'h0 && (!best_v || cls[i] >= best_cls)) begin
        best_v   = 1'b1;
        best_cls = cls[i];
        best_b   = `BANK_IDX_W'(i);
      end
    end
  end

  // ----------------------------------------
  // Queues and frame stage
  // ----------------------------------------
  logic      win_q;
  logic      done;
  logic      accept;
  logic [1:0] q_rdy;
  rx_entry_t win_entry;

  assign win_q = fifo_sel_r[best_b];
  assign win_entry.frame = stage_r;
  assign win_entry.matched_slot_number = {1'b0, slot[best_b]};

  genvar q;
  generate
    for (q = 0; q < 2; q++) begin : g_queue
      frame_fifo #(
        .W ($bits(rx_entry_t)),
        .D (`FIFO_DEPTH)
      ) u_fifo (
        .clk       (sys_clk),
        .arst_n    (arst_n),
        .in_valid  (stage_v_r & best_v & (win_q == 1'(q))),
        .in_ready  (q_rdy[q]),
        .in_data   (win_entry),
        .out_valid (),
        .out_ready (release_req[q]),
        .out_data  (q_head[q]),
        .level     (q_level[q])
      );
    end
  endgenerate

  // Frames that match nothing leave the stage at once
  assign done   = stage_v_r & (~best_v | q_rdy[win_q]);
  assign accept = frame_valid & frame_ready_r;

  always_ff @(posedge sys_clk) begin
    if (accept) begin
      stage_r <= frame_in;
    end
  end

  // A full target queue stalls the receiver side
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_v_r     <= 1'b0;
      frame_ready_r <= 1'b0;
    end else begin
      stage_v_r     <= accept | (stage_v_r & ~done);
      frame_ready_r <= ~(accept | (stage_v_r & ~done));
    end
  end
endmodule : can_rx_acceptance_filter

// [rtl/ignore_me_placeholder_none.sv]
`timescale 1ns/1ps

// [testbench/acc_filter_monitor.sv]
`timescale 1ns/1ps
module acc_filter_monitor
  import acc_filter_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_valid,
  input wire logic        frame_ready,
  input wire rx_frame_t   frame_in
);
  // ----------------------------------------
  // Bus and stream checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_has_cause: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_misaligned: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access accepted");
  a_err_bank_range: assert property (psel && !penable && paddr >= 12'h1E0 |=> pslverr)
    else $error("bank index out of range accepted");
  a_cfg_reg_mapped: assert property (
    psel && !penable && paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0 |=> pready && !pslverr)
    else $error("config register refused");
  a_write_reads_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  a_take_drops_ready: assert property (frame_valid && frame_ready |=> !frame_ready)
    else $error("frame_ready held after take");
endmodule : acc_filter_monitor

bind can_rx_acceptance_filter acc_filter_monitor u_mon (
  .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_in(frame_in)
);

// [testbench/rx_frame_source.sv]
`timescale 1ns/1ps
module rx_frame_source
  import acc_filter_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic frame_ready,
  output logic      frame_valid,
  output rx_frame_t frame_in
);
  initial begin
    frame_valid = 1'b0;
    frame_in    = '0;
  end

  // Holds the offer until taken; the idle cycle keeps one frame per two cycles
  task automatic send(input rx_frame_t f);
    frame_valid <= 1'b1;
    frame_in    <= f;
    do @(posedge sys_clk); while (frame_ready !== 1'b1);
    frame_valid <= 1'b0;
    frame_in    <= ~f;
    @(posedge sys_clk);
  endtask : send
endmodule : rx_frame_source

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "acc_filter_regs.svh"
module testbench
  import acc_filter_pkg::*;
;
  logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, frame_valid, frame_ready, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rx_frame_t   frame_in;
  logic [31:0] fid [64];
  logic [7:0]  fsl [64];
  int          fq [2][$];
  int          error_cnt = 0;
  int          n_compared = 0;

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  can_rx_acceptance_filter DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_in(frame_in));
  rx_frame_source src (.sys_clk(sys_clk), .frame_ready(frame_ready), .frame_valid(frame_valid),
    .frame_in(frame_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] k32(logic [10:0] s, logic [17:0] x, logic f, logic t);
    return {s, x, f, t, 1'b0};
  endfunction : k32

  function automatic logic [15:0] k16(logic [10:0] s, logic t = 0, logic f = 0, logic [2:0] x = 0);
    return {s, t, f, x};
  endfunction : k16

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Idle cycle after each transfer avoids driving psel twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rdc

  task automatic tx(int i, logic [10:0] s, logic [17:0] x, logic f, logic t, int q, int sl);
    rx_frame_t fr;
    fr = '{s, x, f, t, 4'(i), 32'(i), ~32'(i)};
    fid[i] = k32(s, x, f, t);
    fsl[i] = 8'(sl);
    src.send(fr);
    if (q >= 0) fq[q].push_back(i);
  endtask : tx

  task automatic drain(int q);
    logic [11:0] b;
    int          i;
    int          n;
    b = 12'h040 + 12'(32 * q);
    while (fq[q].size() > 0) begin
      n = fq[q].size();
      i = fq[q].pop_front();
      rdc("level", b, 32'(n) | (n == 16 ? 32'h40 : 32'h0));
      rdc("id", b + 12'h4, fid[i]);
      rdc("prop", b + 12'h8, {16'h0, fsl[i], 4'h0, 4'(i)});
      rdc("data_lo", b + 12'hC, 32'(i));
      rdc("data_hi", b + 12'h10, ~32'(i));
      wr(b, 32'h20);
    end
    rdc("empty", b, 32'h0);
  endtask : drain

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    // Roughly four times the ~550 cycles the tests need
    repeat (2000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rdc("mode", `MODE_OFS, 32'h0);
    rdc("scale", `SCALE_OFS, 32'h0);
    rdc("qsel", `FIFO_SEL_OFS, 32'h0);
    rdc("active", `ACTIVE_OFS, 32'h0);
    apb(1'b0, 12'h1E0, 32'h0);
    chk("bank28 err", er, 1'b1);
    apb(1'b1, 12'h102, 32'hFFFF);
    chk("misaligned err", er, 1'b1);
    rdc("bank0 lo", 12'h100, 32'h0);
    wr(12'h100, k32(11'h100, 0, 0, 0));
    wr(12'h104, k32(11'h7F0, 0, 1, 1));
    wr(12'h108, k32(11'h123, 18'h2AAAA, 1, 0));
    wr(12'h10C, k32(11'h100, 0, 0, 0));
    wr(12'h110, {k16(11'h7FF, 1, 1, 3'h7), k16(11'h200)});
    wr(12'h114, {16'hFE1F, k16(11'h300)});
    wr(12'h118, {2{k16(11'h055)}});
    wr(12'h11C, {2{k16(11'h055)}});
    wr(12'h120, {k16(11'h402), k16(11'h101)});
    wr(12'h124, {k16(11'h404), k16(11'h403)});
    rdc("bank4 hi", 12'h124, {k16(11'h404), k16(11'h403)});
    wr(`MODE_OFS, 32'h1A);
    wr(`SCALE_OFS, 32'h03);
    wr(`FIFO_SEL_OFS, 32'h04);
    wr(`ACTIVE_OFS, 32'h17);
    rdc("active", `ACTIVE_OFS, 32'h17);
    tx(1, 11'h10A, 18'h3FFFF, 0, 0, 0, 0);
    tx(2, 11'h100, 18'h0, 0, 0, 0, 2);
    tx(3, 11'h123, 18'h2AAAA, 1, 1, -1, 0);
    tx(4, 11'h123, 18'h2AAAA, 1, 0, 0, 1);
    tx(5, 11'h101, 18'h0, 0, 0, 0, 0);
    tx(6, 11'h055, 18'h0, 0, 0, -1, 0);
    tx(7, 11'h403, 18'h0, 0, 0, 0, 9);
    tx(8, 11'h404, 18'h0, 0, 0, 0, 10);
    tx(9, 11'h200, 18'h07FFF, 0, 0, 1, 0);
    tx(10, 11'h200, 18'h08000, 0, 0, -1, 0);
    tx(11, 11'h30C, 18'h0, 0, 0, 1, 1);
    tx(27, 11'h123, 18'h2AAAB, 1, 0, -1, 0);
    drain(0);
    for (int i = 12; i < 26; i++) tx(i, 11'h200, 18'h0, 0, 0, 1, 0);
    rdc("full", 12'h060, 32'h50);
    fork
      tx(26, 11'h200, 18'h0, 0, 0, 1, 0);
    join_none
    repeat (5) @(posedge sys_clk);
    chk("stall", frame_ready, 1'b0);
    void'(fq[1].pop_front());
    wr(12'h060, 32'h20);
    wait fork;
    drain(1);
    give_verdict();
  end
endmodule : testbench
